// ### rtl/sync_serial_pkg.sv
package sync_serial_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0] ADDR_SHIFT_DATA   = 8'h2A;
  localparam logic [7:0] ADDR_CONTROL_ONE  = 8'h2B;
  localparam logic [7:0] ADDR_CONTROL_TWO  = 8'h2C;
  localparam logic [7:0] ADDR_STAGE_ONE    = 8'h2D;
  localparam logic [7:0] ADDR_STAGE_TWO    = 8'h2E;
  localparam logic [7:0] ADDR_RATE_MODE    = 8'h2F;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_SHIFT_DATA    = 8'h00;
  localparam logic [7:0] RST_CONTROL_ONE   = 8'h00;
  localparam logic [7:0] RST_CONTROL_TWO   = 8'h00;
  localparam logic [7:0] RST_STAGE         = 8'hFF;
  localparam logic [7:0] RST_RATE_MODE     = 8'h00;
  localparam logic [7:0] READ_UNMAPPED     = 8'h00;

  // ==========================================================================
  // serial_control_one fields
  localparam int DIV_SELECT_LSB            = 0;
  localparam int PIN_FUNCTION_SELECT       = 3;
  localparam int READY_PIN_SELECT          = 4;
  localparam int BIT_ORDER_SELECT          = 5;
  localparam int CLOCK_SOURCE_SELECT       = 6;
  localparam int TXD_DRIVE_SELECT          = 7;

  // serial_control_two fields, bits 7..3 read as zero
  localparam int SLAVE_SELECT              = 0;
  localparam int INTERNAL_CLOCK_PICK       = 1;
  localparam int RX_INPUT_SELECT           = 2;
  localparam logic [7:0] CONTROL_TWO_MASK  = 8'h07;

  // rate_generator_mode fields, bits 7..4 read as zero
  localparam int STAGE1_WRITE_MODE         = 0;
  localparam int STAGE1_HALT               = 1;
  localparam int STAGE2_WRITE_MODE         = 2;
  localparam int RATE_CLOCK_ENABLE         = 3;
  localparam logic [7:0] RATE_MODE_MASK    = 8'h0F;

  // ==========================================================================
  // counts
  localparam logic [2:0] BITS_PER_BYTE_M1  = 3'h7;
  localparam logic [7:0] STAGE_ZERO        = 8'h00;

  typedef enum logic [0:0] {
    XFER_IDLE   = 1'b0,
    XFER_ACTIVE = 1'b1
  } xfer_state_t;

endpackage : sync_serial_pkg

// ### rtl/sync_serial_with_rate_generator.sv
// Local design decision: the plain strobed port.
`timescale 1ns/1ns

module sync_serial_with_rate_generator (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       sclk_in,
  output logic            sclk_out,
  output logic            sclk_oe,
  input  wire logic       rx_pin,
  output logic            tx_pin_out,
  output logic            tx_pin_oe,
  input  wire logic       ready_line_in,
  output logic            ready_line_out,
  output logic            ready_line_oe,
  output logic            serial_irq,
  output logic            rate_clock_out
);

  // ==========================================================================
  // helpers
  function automatic logic out_bit(input logic [7:0] value, input logic msb_first);
    out_bit = msb_first ? value[7] : value[0];
  endfunction : out_bit

  function automatic logic [7:0] shift_in(input logic [7:0] value, input logic bit_in,
                                          input logic msb_first);
    shift_in = msb_first ? {value[6:0], bit_in} : {bit_in, value[7:1]};
  endfunction : shift_in

  // ==========================================================================
  // registers
  logic [7:0] shift_data;
  logic [7:0] control_one;
  logic [7:0] control_two;
  logic [7:0] stage_one_latch;
  logic [7:0] stage_one_count;
  logic [7:0] stage_two_latch;
  logic [7:0] stage_two_count;
  logic [7:0] rate_mode;

  logic wr_shift;
  logic wr_ctl1;
  logic wr_ctl2;
  logic wr_stage1;
  logic wr_stage2;
  logic wr_mode;

  assign wr_shift  = wr && (addr == sync_serial_pkg::ADDR_SHIFT_DATA);
  assign wr_ctl1   = wr && (addr == sync_serial_pkg::ADDR_CONTROL_ONE);
  assign wr_ctl2   = wr && (addr == sync_serial_pkg::ADDR_CONTROL_TWO);
  assign wr_stage1 = wr && (addr == sync_serial_pkg::ADDR_STAGE_ONE);
  assign wr_stage2 = wr && (addr == sync_serial_pkg::ADDR_STAGE_TWO);
  assign wr_mode   = wr && (addr == sync_serial_pkg::ADDR_RATE_MODE);

  // control fields
  logic [2:0] div_select;
  logic       pin_function_select;
  logic       ready_pin_select;
  logic       bit_order_select;
  logic       clock_source_select;
  logic       txd_drive_select;
  logic       internal_clock_pick;
  logic       rx_input_select;
  logic       slave_mode;
  logic       stage1_write_mode;
  logic       stage1_halt;
  logic       stage2_write_mode;
  logic       rate_clock_enable;

  assign div_select          = control_one[sync_serial_pkg::DIV_SELECT_LSB +: 3];
  assign pin_function_select = control_one[sync_serial_pkg::PIN_FUNCTION_SELECT];
  assign ready_pin_select    = control_one[sync_serial_pkg::READY_PIN_SELECT];
  assign bit_order_select    = control_one[sync_serial_pkg::BIT_ORDER_SELECT];
  assign clock_source_select = control_one[sync_serial_pkg::CLOCK_SOURCE_SELECT];
  assign txd_drive_select    = control_one[sync_serial_pkg::TXD_DRIVE_SELECT];
  assign internal_clock_pick = control_two[sync_serial_pkg::INTERNAL_CLOCK_PICK];
  assign rx_input_select     = control_two[sync_serial_pkg::RX_INPUT_SELECT];
  assign slave_mode          = control_two[sync_serial_pkg::SLAVE_SELECT]
                               && ready_pin_select;
  assign stage1_write_mode   = rate_mode[sync_serial_pkg::STAGE1_WRITE_MODE];
  assign stage1_halt         = rate_mode[sync_serial_pkg::STAGE1_HALT];
  assign stage2_write_mode   = rate_mode[sync_serial_pkg::STAGE2_WRITE_MODE];
  assign rate_clock_enable   = rate_mode[sync_serial_pkg::RATE_CLOCK_ENABLE];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      control_one <= sync_serial_pkg::RST_CONTROL_ONE;
      control_two <= sync_serial_pkg::RST_CONTROL_TWO;
      rate_mode   <= sync_serial_pkg::RST_RATE_MODE;
    end else begin
      if (wr_ctl1) begin
        control_one <= wdata;
      end
      if (wr_ctl2) begin
        control_two <= wdata & sync_serial_pkg::CONTROL_TWO_MASK;
      end
      if (wr_mode) begin
        rate_mode <= wdata & sync_serial_pkg::RATE_MODE_MASK;
      end
    end
  end

  // ==========================================================================
  // read port, data in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= sync_serial_pkg::READ_UNMAPPED;
    end else if (rd) begin
      if (addr == sync_serial_pkg::ADDR_SHIFT_DATA) begin
        rdata <= shift_data;
      end else if (addr == sync_serial_pkg::ADDR_CONTROL_ONE) begin
        rdata <= control_one;
      end else if (addr == sync_serial_pkg::ADDR_CONTROL_TWO) begin
        rdata <= control_two;
      end else if (addr == sync_serial_pkg::ADDR_STAGE_ONE) begin
        rdata <= stage_one_count;
      end else if (addr == sync_serial_pkg::ADDR_STAGE_TWO) begin
        rdata <= stage_two_count;
      end else if (addr == sync_serial_pkg::ADDR_RATE_MODE) begin
        rdata <= rate_mode;
      end else begin
        rdata <= sync_serial_pkg::READ_UNMAPPED;
      end
    end else begin
      rdata <= sync_serial_pkg::READ_UNMAPPED;
    end
  end

  // ==========================================================================
  // rate generator
  logic stage1_run;
  logic stage1_underflow;
  logic stage2_pulse;
  logic stage2_underflow;

  assign stage1_run       = rate_clock_enable && !stage1_halt;
  assign stage1_underflow = stage1_run && (stage_one_count == sync_serial_pkg::STAGE_ZERO);
  // stage two loses one system clock per stage one underflow
  assign stage2_pulse     = rate_clock_enable && (stage1_halt || !stage1_underflow);
  assign stage2_underflow = stage2_pulse && (stage_two_count == sync_serial_pkg::STAGE_ZERO);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage_one_latch <= sync_serial_pkg::RST_STAGE;
      stage_one_count <= sync_serial_pkg::RST_STAGE;
    end else begin
      if (wr_stage1) begin
        stage_one_latch <= wdata;
      end
      if (wr_stage1 && !stage1_write_mode) begin
        stage_one_count <= wdata;
      end else if (stage1_underflow) begin
        // a deferred write reaches the counter here through the latch
        stage_one_count <= wr_stage1 ? wdata : stage_one_latch;
      end else if (stage1_run) begin
        stage_one_count <= stage_one_count - 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage_two_latch <= sync_serial_pkg::RST_STAGE;
      stage_two_count <= sync_serial_pkg::RST_STAGE;
    end else begin
      if (wr_stage2) begin
        stage_two_latch <= wdata;
      end
      if (wr_stage2 && !stage2_write_mode) begin
        stage_two_count <= wdata;
      end else if (stage2_underflow) begin
        stage_two_count <= wr_stage2 ? wdata : stage_two_latch;
      end else if (stage2_pulse) begin
        stage_two_count <= stage_two_count - 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rate_clock_out <= 1'b0;
    end else begin
      rate_clock_out <= stage2_underflow && rate_clock_enable;
    end
  end

  // ==========================================================================
  // pin synchronisers
  logic sclk_meta;
  logic sclk_sync;
  logic sclk_prev;
  logic rx_meta;
  logic rx_sync;
  logic ready_meta;
  logic ready_sync;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclk_meta  <= 1'b1;
      sclk_sync  <= 1'b1;
      sclk_prev  <= 1'b1;
      rx_meta    <= 1'b0;
      rx_sync    <= 1'b0;
      ready_meta <= 1'b1;
      ready_sync <= 1'b1;
    end else begin
      sclk_meta  <= sclk_in;
      sclk_sync  <= sclk_meta;
      sclk_prev  <= sclk_sync;
      rx_meta    <= rx_pin;
      rx_sync    <= rx_meta;
      ready_meta <= ready_line_in;
      ready_sync <= ready_meta;
    end
  end

  // ==========================================================================
  // internal shift clock
  logic                         src_tick;
  logic [6:0]                   div_count;
  logic [6:0]                   half_period_m1;
  logic                         div_wrap;
  logic                         int_mode;
  logic                         slave_block;
  logic                         clock_done;
  logic [2:0]                   rise_count;
  logic                         int_toggle;
  logic                         int_fall;
  logic                         int_rise;
  logic                         rise_d1;
  logic                         rise_d2;
  sync_serial_pkg::xfer_state_t state;

  assign int_mode       = clock_source_select;
  assign slave_block    = slave_mode && ready_sync;
  // with the rate generator stopped this source never ticks and a byte stalls
  assign src_tick       = internal_clock_pick ? stage2_underflow : 1'b1;
  assign half_period_m1 = 7'((8'h01 << div_select) - 8'h01);
  assign div_wrap       = src_tick && (div_count == half_period_m1);
  assign int_toggle     = int_mode && !clock_done && !slave_block && div_wrap
                          && (state == sync_serial_pkg::XFER_ACTIVE);
  assign int_fall       = int_toggle && sclk_out;
  assign int_rise       = int_toggle && !sclk_out;

  // the receive pin arrives two clocks late, so each sample trails its rising edge by two
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_count  <= 7'h00;
      sclk_out   <= 1'b1;
      sclk_oe    <= 1'b0;
      rise_count <= 3'h0;
      clock_done <= 1'b1;
      rise_d1    <= 1'b0;
      rise_d2    <= 1'b0;
    end else begin
      div_count <= (wr_shift || div_wrap) ? 7'h00 : div_count + 7'(src_tick);
      sclk_oe   <= pin_function_select && int_mode;
      rise_d1   <= int_rise;
      rise_d2   <= rise_d1;
      if (wr_shift) begin
        sclk_out   <= 1'b1;
        rise_count <= 3'h0;
        clock_done <= 1'b0;
      end else if (slave_block) begin
        rise_count <= 3'h0;
      end else if (int_toggle) begin
        sclk_out <= !sclk_out;
        if (int_rise) begin
          rise_count <= rise_count + 3'h1;
          clock_done <= (rise_count == sync_serial_pkg::BITS_PER_BYTE_M1);
        end
      end
    end
  end

  // ==========================================================================
  // shift engine
  logic       ext_rise;
  logic       ext_fall;
  logic       sample_evt;
  logic       fall_evt;
  logic       pending;
  logic       rx_bit;
  logic [2:0] bit_count;
  logic       byte_done;
  logic [7:0] tx_source;
  logic       tx_level;
  logic       next_tx_level;
  logic       tx_drive;

  assign ext_rise   = !int_mode && !slave_block && sclk_sync && !sclk_prev;
  assign ext_fall   = !int_mode && !slave_block && !sclk_sync && sclk_prev;
  assign sample_evt = int_mode ? rise_d2 : ext_rise;
  assign fall_evt   = int_mode ? int_fall : ext_fall;
  // a rising edge still waiting for its sample has not shifted the register yet
  assign pending    = int_mode && (rise_d1 || rise_d2);
  assign tx_source  = pending ? shift_in(shift_data, 1'b0, bit_order_select) : shift_data;
  assign rx_bit     = rx_input_select && rx_sync;
  assign byte_done  = sample_evt && (bit_count == sync_serial_pkg::BITS_PER_BYTE_M1);
  // internal clock floats the pin between bytes, external clock keeps it driven
  assign tx_drive   = pin_function_select && !slave_block
                      && (!int_mode || wr_shift || (state == sync_serial_pkg::XFER_ACTIVE));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift_data <= sync_serial_pkg::RST_SHIFT_DATA;
      bit_count  <= 3'h0;
      state      <= sync_serial_pkg::XFER_IDLE;
      serial_irq <= 1'b0;
    end else begin
      serial_irq <= byte_done;
      if (wr_shift) begin
        shift_data <= wdata;
        bit_count  <= 3'h0;
        state      <= sync_serial_pkg::XFER_ACTIVE;
      end else begin
        if (sample_evt) begin
          shift_data <= shift_in(shift_data, rx_bit, bit_order_select);
        end
        if (slave_block) begin
          bit_count <= 3'h0;
        end else if (sample_evt) begin
          bit_count <= bit_count + 3'h1;
        end
        if (byte_done) begin
          state <= sync_serial_pkg::XFER_IDLE;
        end
      end
    end
  end

  always_comb begin
    next_tx_level = tx_level;
    if (wr_shift) begin
      next_tx_level = out_bit(wdata, bit_order_select);
    end else if (fall_evt) begin
      next_tx_level = out_bit(tx_source, bit_order_select);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_level   <= 1'b1;
      tx_pin_out <= 1'b1;
      tx_pin_oe  <= 1'b0;
    end else begin
      tx_level   <= next_tx_level;
      // open drain never drives a one; the pin only sinks for a zero
      tx_pin_out <= next_tx_level && !txd_drive_select;
      tx_pin_oe  <= tx_drive && (!txd_drive_select || !next_tx_level);
    end
  end

  // ==========================================================================
  // ready handshake pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ready_line_out <= 1'b1;
      ready_line_oe  <= 1'b0;
    end else begin
      // outside slave mode the pin goes low from the load of a byte until its last bit is sampled
      ready_line_out <= (state != sync_serial_pkg::XFER_ACTIVE);
      ready_line_oe  <= ready_pin_select && !slave_mode;
    end
  end

endmodule : sync_serial_with_rate_generator

// ### verification/sync_serial_properties.sv
`timescale 1ns/1ns
// ==========================================================================
// port checker
module sync_serial_properties (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       sclk_in,
  input wire logic       sclk_out,
  input wire logic       sclk_oe,
  input wire logic       rx_pin,
  input wire logic       tx_pin_out,
  input wire logic       tx_pin_oe,
  input wire logic       ready_line_in,
  input wire logic       ready_line_out,
  input wire logic       ready_line_oe,
  input wire logic       serial_irq,
  input wire logic       rate_clock_out
);
  logic [7:0] c1, c2, md;
  logic       slv;
  assign slv = c2[0] & c1[4];
  // shadow copies from the write strobe, so no body signal is needed
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      c1 <= 8'h00;
      c2 <= 8'h00;
      md <= 8'h00;
    end else if (wr) begin
      if (addr == 8'h2B) c1 <= wdata;
      if (addr == 8'h2C) c2 <= wdata;
      if (addr == 8'h2F) md <= wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // fast divider codes only, keeps the bound short
  sequence s_int_start;
    wr && addr == 8'h2A && c1[6] && c1[3] && !slv && !c2[1] && c1[2:0] < 3'h4;
  endsequence
  a_rate_clock_off: assert property (!md[3] && !$past(md[3]) |-> !rate_clock_out)
    else $error("rate clock not held off");
  a_gpio_pins_off: assert property (!c1[3] && !$past(c1[3]) |-> !tx_pin_oe && !sclk_oe)
    else $error("pins driven as port pins");
  a_ext_clock_in: assert property (!c1[6] && !$past(c1[6]) |-> !sclk_oe)
    else $error("clock pin driven in external mode");
  a_ready_is_input: assert property (slv && $past(slv) |-> !ready_line_oe)
    else $error("ready pin driven in slave mode");
  a_slave_float: assert property ((slv && ready_line_in)[*4] |-> !tx_pin_oe)
    else $error("tx driven while ready high");
  a_open_drain: assert property (c1[7] && $past(c1[7]) && tx_pin_oe |-> !tx_pin_out)
    else $error("open drain drives high");
  a_ctl_readback: assert property (rd && addr == 8'h2B |=> rdata == c1)
    else $error("control one readback wrong");
  a_irq_on_byte: assert property (s_int_start |-> ##[1:200] serial_irq)
    else $error("no request after byte");
  a_float_after: assert property ($rose(serial_irq) && c1[6] && !slv |-> ##[0:40] !tx_pin_oe)
    else $error("tx not floated after byte");
endmodule : sync_serial_properties

bind sync_serial_with_rate_generator sync_serial_properties u_props (.clk, .rst_n, .addr,
  .wdata, .wr, .rd, .rdata, .sclk_in, .sclk_out, .sclk_oe, .rx_pin, .tx_pin_out, .tx_pin_oe,
  .ready_line_in, .ready_line_out, .ready_line_oe, .serial_irq, .rate_clock_out);

// ### verification/serial_peer.sv
`timescale 1ns/1ns
// ==========================================================================
// far-side serial device
module serial_peer (
  input  wire logic       sclk,
  input  wire logic       tx_line,
  output logic            rx_line,
  output logic            ext_sclk,
  output logic      [7:0] captured
);
  logic [7:0] src;
  logic       msb;
  int         idx;
  initial begin
    rx_line = 1'b1;
    ext_sclk = 1'b1;
    captured = 8'h00;
    msb = 1'b0;
    idx = 8;
  end
  // past the frame the line wobbles, so a stale bit never passes
  always @(negedge sclk) rx_line <= (idx > 7) ? ~rx_line : src[msb ? 7 - idx : idx];
  always @(posedge sclk) begin
    captured <= msb ? {captured[6:0], tx_line} : {tx_line, captured[7:1]};
    idx <= idx + 1;
  end
  task automatic load(input logic [7:0] b, input logic m);
    src = b;
    msb = m;
    idx = 0;
    rx_line = m ? b[7] : b[0];
  endtask : load
  // clock only inside the frame, exactly n pulses
  task automatic pulses(input int n);
    repeat (n) begin
      #100 ext_sclk = 1'b0;
      #100 ext_sclk = 1'b1;
    end
  endtask : pulses
endmodule : serial_peer

// ### verification/test_sync_serial_with_rate_generator.sv
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
// ==========================================================================
// bench top
module test_sync_serial_with_rate_generator;
  logic       clk, rst_n, wr, rd, rx_pin, sclk_out, sclk_oe, tx_pin_out, tx_pin_oe, ext;
  logic       ready_in, ready_line_out, ready_line_oe, serial_irq, rate_clock_out, prev;
  logic [7:0] addr, wdata, rdata, cap, tx, rxb;
  logic [7:0] rst_tab [5] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00};
  int         n_errors = 0, checked = 0, cyc = 0, rise_at = 0, gap = 0, n;
  wire        sclk_in       = sclk_oe ? sclk_out : ext;
  wire        ready_line_in = ready_line_oe ? ready_line_out : ready_in;
  wire        tx_w          = tx_pin_oe ? tx_pin_out : 1'b1;
  sync_serial_with_rate_generator u_dut (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
    .sclk_in, .sclk_out, .sclk_oe, .rx_pin, .tx_pin_out, .tx_pin_oe, .ready_line_in,
    .ready_line_out, .ready_line_oe, .serial_irq, .rate_clock_out);
  serial_peer u_peer (.sclk(sclk_in), .tx_line(tx_w), .rx_line(rx_pin), .ext_sclk(ext),
    .captured(cap));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // shift clock period in system cycles, last two rising edges
  always @(posedge clk) begin
    cyc++;
    prev <= sclk_in;
    if (sclk_in && !prev) begin
      gap = cyc - rise_at;
      rise_at = cyc;
    end
  end
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  // one bus cycle, then an idle cycle so strobes never reassign in one step
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    if (!w) `CHK(rdata, v)
    @(posedge clk);
  endtask : acc
  task automatic wait_irq();
    int k;
    for (k = 0; k < 5000 && serial_irq !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 5000) begin
      n_errors++;
      summarize();
    end
  endtask : wait_irq
  task automatic xfer(input logic [2:0] code, input logic pick, input int exp_gap);
    logic [1:0] r;
    r = $urandom;
    tx = $urandom;
    rxb = $urandom;
    acc(1'b1, 8'h2C, {6'h01, pick, 1'b0});
    acc(1'b1, 8'h2B, {r[1], 1'b1, r[0], 2'b01, code});
    u_peer.load(rxb, r[0]);
    acc(1'b1, 8'h2A, tx);
    wait_irq();
    repeat (40) @(posedge clk);
    #1;
    `CHK(cap, tx)
    `CHK(gap, exp_gap)
    `CHK(tx_pin_oe, 1'b0)
    acc(1'b0, 8'h2A, rxb);
  endtask : xfer
  initial begin
    {rst_n, wr, rd, ready_in} = 4'h0;
    addr = 8'h00;
    wdata = 8'h00;
    void'($urandom(62));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    foreach (rst_tab[i]) acc(1'b0, 8'h2B + 8'(i), rst_tab[i]);
    acc(1'b0, 8'h30, sync_serial_pkg::READ_UNMAPPED);
    n = $urandom;
    acc(1'b1, 8'h2C, 8'(n));
    acc(1'b0, 8'h2C, 8'(n) & sync_serial_pkg::CONTROL_TWO_MASK);
    for (int c = 0; c < 8; c++) xfer(3'(c), 1'b0, 2 << c);
    n = $urandom_range(7, 1);
    acc(1'b1, 8'h2F, 8'h0A);
    acc(1'b1, 8'h2E, 8'(n));
    xfer(3'h0, 1'b1, 2 * (n + 1));
    acc(1'b1, 8'h2C, 8'h05);
    acc(1'b1, 8'h2B, 8'h18);
    ready_in <= 1'b1;
    tx = $urandom;
    rxb = $urandom;
    u_peer.load(rxb, 1'b0);
    acc(1'b1, 8'h2A, tx);
    repeat (4) @(posedge clk);
    #1;
    `CHK(tx_pin_oe, 1'b0)
    ready_in <= 1'b0;
    fork
      u_peer.pulses(8);
      wait_irq();
    join
    repeat (4) @(posedge clk);
    #1;
    `CHK(cap, tx)
    `CHK(tx_pin_oe, 1'b1)
    acc(1'b0, 8'h2A, rxb);
    summarize();
  end
endmodule : test_sync_serial_with_rate_generator
